// >>> design/mpp_pkg.sv
// constants for the parallel memory port
package mpp_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 8;
  localparam int          MEM_DEPTH     = 4096;
  // implemented locations: the whole 4 kB data memory
  localparam logic [11:0] IMPL_LO       = 12'h000;
  localparam logic [11:0] IMPL_HI       = 12'hfff;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;
  localparam logic [11:0] PTR_RESET     = 12'h000;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          LOCKOUT_MS    = 12;
  localparam int          LOCKOUT_CYCLES =
    (LOCKOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int          LOCK_W        = 21;
  localparam logic [DATA_W-1:0] MEM_RESET = 8'h00;
endpackage

// >>> design/mpp_mem.sv
// byte-wide memory with registered read data
`timescale 1ns/1ps
module mpp_mem
  import mpp_pkg::*;
(
  // clock
  input  wire logic              mclk,
  // write side
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // read side
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] rd_data_reg;

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_reg <= mem[rd_addr];
  end

  assign rd_data = rd_data_reg;
endmodule

// >>> design/mpp_port.sv
// parallel memory port: strobe framing, pointer, lockout, data drive
//
// Overview of operation
// - write starts with select and store strobe low
// - drive data until select or read released
// - writes to unmapped addresses change nothing
// - reads from unmapped addresses return zero
// - mode strap: low indirect, high direct
// - indirect accesses use internal 12-bit pointer
// - indirect data access steps pointer by one
// - address-phase write loads pointer from A11:8, data
// - indirect data phase moves one byte per access
// - indirect mode ignores low address pins
// - direct mode uses full 12-bit pins
// - direct mode never advances any address
// - direct mode ignores address-phase select
// - full 4 kB space decoded under select
// - 12 ms lockout after master reset
// - no lockout after usb bus reset
`timescale 1ns/1ps
module mpp_port
  import mpp_pkg::*;
#(
  parameter int LOCKOUT = LOCKOUT_CYCLES
)
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // host strobes and strap, all asynchronous pins
  input  wire logic              cs_n,
  input  wire logic              wr_n,
  input  wire logic              rd_n,
  input  wire logic              addr_phase_select,
  input  wire logic              mode,
  input  wire logic [ADDR_W-1:0] addr,
  // data pins
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe_n,
  // status
  output logic                   locked,
  output logic      [ADDR_W-1:0] byte_pointer
);
  // access states
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} mpp_state_t;

  // every pin passes two flip-flops; first stage read only by second
  logic [3:0] ctl_pin;
  logic [3:0] ctl_s2;
  assign ctl_pin = {cs_n, wr_n, rd_n, addr_phase_select};

  genvar g;
  generate
    for (g = 0; g < $bits(ctl_pin); g = g + 1) begin : g_ctl_sync
      logic s1_reg;
      logic s2_reg;
      always_ff @(posedge mclk) begin
        s1_reg <= ctl_pin[g];
        s2_reg <= s1_reg;
      end
      assign ctl_s2[g] = s2_reg;
    end
  endgenerate

  // buses settle inside a frame, so no gray code is needed
  logic              mode_s1_reg, mode_s2_reg;
  logic [ADDR_W-1:0] addr_s1_reg, addr_s2_reg;
  logic [DATA_W-1:0] din_s1_reg, din_s2_reg;

  always_ff @(posedge mclk) begin
    mode_s1_reg <= mode;
    mode_s2_reg <= mode_s1_reg;
    addr_s1_reg <= addr;
    addr_s2_reg <= addr_s1_reg;
    din_s1_reg  <= data_in;
    din_s2_reg  <= din_s1_reg;
  end

  // strobe levels after synchronisation, active high
  logic cs_act;
  logic wr_act;
  logic rd_act;
  logic ads_s;
  logic wr_hold;
  logic rd_hold;
  assign cs_act  = ~ctl_s2[3];
  assign wr_act  = ~ctl_s2[2];
  assign rd_act  = ~ctl_s2[1];
  assign ads_s   = ctl_s2[0];
  assign wr_hold = cs_act & wr_act;
  assign rd_hold = cs_act & rd_act;

  // every location of the 4 kB space is decoded under select
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a >= IMPL_LO) && (a <= IMPL_HI);
  endfunction

  // lockout group: master reset only, a bus reset never reaches here
  logic [LOCK_W-1:0] lock_cnt_reg, lock_cnt_next;
  logic              locked_reg, locked_next;

  always_comb begin
    lock_cnt_next = lock_cnt_reg;
    locked_next   = locked_reg;
    if (locked_reg) begin
      if (lock_cnt_reg == LOCK_W'(LOCKOUT - 1)) begin
        locked_next = 1'b0;
      end else begin
        lock_cnt_next = lock_cnt_reg + LOCK_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lock_cnt_reg <= '0;
      locked_reg   <= 1'b1;
    end else begin
      lock_cnt_reg <= lock_cnt_next;
      locked_reg   <= locked_next;
    end
  end

  // strap group: taken once after release, then frozen
  logic mode_reg, mode_next;
  logic strap_done_reg, strap_done_next;

  always_comb begin
    mode_next       = mode_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg) begin
      mode_next = mode_s2_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mode_reg       <= 1'b0;
      strap_done_reg <= 1'b0;
    end else begin
      mode_reg       <= mode_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // effective location for the current access
  logic [ADDR_W-1:0] ptr_reg, ptr_next;
  logic [ADDR_W-1:0] eff_addr;

  // low address pins unused in indirect mode, pointer unused in direct mode
  always_comb begin
    if (mode_reg) begin
      eff_addr = addr_s2_reg;
    end else begin
      eff_addr = ptr_reg;
    end
  end

  // access group: frames an access and raises one commit at its end
  mpp_state_t        state_reg, state_next;
  logic [ADDR_W-1:0] wa_reg, wa_next;
  logic [3:0]        wa_hi_reg, wa_hi_next;
  logic [DATA_W-1:0] wd_reg, wd_next;
  logic              wads_reg, wads_next;
  logic              rd_mapped_reg, rd_mapped_next;
  logic              mem_we;
  logic              ptr_load;
  logic              ptr_step;

  always_comb begin
    state_next     = state_reg;
    wa_next        = wa_reg;
    wa_hi_next     = wa_hi_reg;
    wd_next        = wd_reg;
    wads_next      = wads_reg;
    rd_mapped_next = rd_mapped_reg;
    mem_we         = 1'b0;
    ptr_load       = 1'b0;
    ptr_step       = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // nothing is taken while the clock source settles
        if (!locked_reg && wr_hold) begin
          state_next = ST_WRITE;
          // capture now so a short frame never reuses old values
          wa_next    = eff_addr;
          wa_hi_next = addr_s2_reg[ADDR_W-1:DATA_W];
          wd_next    = din_s2_reg;
          wads_next  = ads_s & ~mode_reg;
        end else if (!locked_reg && rd_hold) begin
          state_next     = ST_READ;
          rd_mapped_next = is_mapped(eff_addr);
        end
      end
      ST_WRITE: begin
        if (wr_hold) begin
          // follow address and data while both strobes stay low
          wa_next    = eff_addr;
          wa_hi_next = addr_s2_reg[ADDR_W-1:DATA_W];
          wd_next    = din_s2_reg;
          wads_next  = ads_s & ~mode_reg;
        end else begin
          // one commit at release, so a held strobe repeats nothing
          state_next = ST_IDLE;
          if (wads_reg) begin
            ptr_load = 1'b1;
          end else begin
            mem_we   = is_mapped(wa_reg);
            ptr_step = ~mode_reg;
          end
        end
      end
      ST_READ: begin
        rd_mapped_next = is_mapped(eff_addr);
        if (!rd_hold) begin
          state_next = ST_IDLE;
          ptr_step   = ~mode_reg;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_reg     <= ST_IDLE;
      wa_reg        <= '0;
      wa_hi_reg     <= '0;
      wd_reg        <= '0;
      wads_reg      <= 1'b0;
      rd_mapped_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      wa_reg        <= wa_next;
      wa_hi_reg     <= wa_hi_next;
      wd_reg        <= wd_next;
      wads_reg      <= wads_next;
      rd_mapped_reg <= rd_mapped_next;
    end
  end

  // pointer group: loaded by an address-phase write, stepped after data
  always_comb begin
    ptr_next = ptr_reg;
    if (ptr_load) begin
      ptr_next = {wa_hi_reg, wd_reg};
    end else if (ptr_step) begin
      // wraps from the top of the space back to zero
      ptr_next = ptr_reg + ADDR_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ptr_reg <= PTR_RESET;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // output group: read data and drive enable, both registered
  logic [DATA_W-1:0] mem_q;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic              oe_n_reg, oe_n_next;

  always_comb begin
    dout_next = dout_reg;
    oe_n_next = 1'b1;
    if (state_reg == ST_READ && rd_hold) begin
      // drive until either strobe is seen released
      oe_n_next = 1'b0;
      dout_next = rd_mapped_reg ? mem_q : UNMAPPED_DATA;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dout_reg <= '0;
      oe_n_reg <= 1'b1;
    end else begin
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // read address follows the access every cycle; data lags one clock
  mpp_mem u_mem (
    .mclk    (mclk),
    .wr_en   (mem_we),
    .wr_addr (wa_reg),
    .wr_data (wd_reg),
    .rd_addr (eff_addr),
    .rd_data (mem_q)
  );

  assign data_out     = dout_reg;
  assign data_oe_n    = oe_n_reg;
  assign locked       = locked_reg;
  assign byte_pointer = ptr_reg;
endmodule

// >>> bench/mpp_host.sv
// host model that frames accesses on the memory port
`timescale 1ns/1ps
module mpp_host (
  // clock and device side
  input  wire logic        mclk,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe_n,
  // host pins
  output logic             cs_n,
  output logic             wr_n,
  output logic             rd_n,
  output logic             aps,
  output logic [11:0]      addr,
  output logic [7:0]       data_in
);
  logic [7:0] hd = 8'h5a;
  initial {cs_n, wr_n, rd_n, aps, addr} = {3'h7, 1'b0, 12'h000};
  // undriven lines show the inverse of the last byte, not a stale copy
  assign data_in = data_oe_n ? hd : data_out;
  // one access at a time; aps, address and data outlast the gap
  task automatic xfer(input logic w, input logic s, input logic [11:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    #1;
    {aps, addr, hd} = {s, a, w ? d : ~d};
    {cs_n, wr_n, rd_n} = {1'b0, !w, w};
    repeat (8) @(posedge mclk);
    q = data_oe_n ? 8'hxx : data_out;
    #1;
    {cs_n, wr_n, rd_n} = 3'h7;
    repeat (5) @(posedge mclk);
    #1;
    aps = 1'b0;
    hd = ~hd;
  endtask
endmodule

// >>> bench/mpp_port_chk.sv
// assertions on the memory port pins
`timescale 1ns/1ps
module mpp_port_chk
  import mpp_pkg::*;
#(
  parameter int LOCKOUT = LOCKOUT_CYCLES
)
(
  // clock, reset and host pins
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              cs_n,
  input wire logic              wr_n,
  input wire logic              rd_n,
  input wire logic              addr_phase_select,
  input wire logic              mode,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_in,
  // device outputs
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe_n,
  input wire logic              locked,
  input wire logic [ADDR_W-1:0] byte_pointer
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_reset_state: assert property (disable iff (1'b0) !nrst |=>
    data_oe_n && locked && byte_pointer == PTR_RESET)
    else $error("outputs not at reset values");
  chk_lock_quiet: assert property (locked |-> data_oe_n)
    else $error("data driven during lockout");
  chk_lock_hold: assert property (locked |=> $stable(byte_pointer))
    else $error("pointer moved during lockout");
  chk_read_drive: assert property ((!cs_n && !rd_n && !locked)[*6]
    |-> !data_oe_n) else $error("read data not driven");
  chk_read_release: assert property ((cs_n || rd_n)[*5] |-> data_oe_n)
    else $error("data still driven after release");
  chk_once_release: assert property ((!cs_n)[*7]
    |-> $stable(byte_pointer)) else $error("pointer moved mid access");
  chk_direct_fixed: assert property (mode && !locked
    |=> $stable(byte_pointer)) else $error("pointer moved in direct mode");
  chk_ptr_step: assert property ($changed(byte_pointer)
    && !addr_phase_select |-> byte_pointer == $past(byte_pointer) + 12'h001)
    else $error("pointer step not one");
  cov_read: cover property (!data_oe_n);
  cov_load: cover property (addr_phase_select && $changed(byte_pointer));
  cov_unlock: cover property ($fell(locked));
endmodule
bind mpp_port mpp_port_chk #(.LOCKOUT(LOCKOUT)) u_chk (.mclk(mclk),
  .nrst(nrst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .mode(mode),
  .addr_phase_select(addr_phase_select), .addr(addr), .data_in(data_in),
  .data_out(data_out), .data_oe_n(data_oe_n), .locked(locked),
  .byte_pointer(byte_pointer));

// >>> bench/mpp_port_tb.sv
// testbench for the parallel memory port
`timescale 1ns/1ps
module mpp_port_tb;
  import mpp_pkg::*;
  logic        mclk = 0, nrst = 0, mode = 1;
  logic        cs_n, wr_n, rd_n, aps, data_oe_n, locked;
  logic [11:0] addr, byte_pointer;
  logic [7:0]  data_in, data_out, q;
  int          bad_count = 0, tests_run = 0;
  // write, aps, address, data; direct mode, aps high must be ignored;
  // the last row leaves a known byte for the lockout test
  logic [21:0] rows [9] = '{{2'b10, 20'h123a5}, {2'b10, 20'hfff3c},
    {2'b10, 20'h0005a}, {2'b11, 20'h20077}, {2'b00, 20'h123a5},
    {2'b00, 20'hfff3c}, {2'b00, 20'h0005a}, {2'b01, 20'h20077},
    {2'b10, 20'h05033}};
  initial forever #5 mclk = ~mclk;
  mpp_port #(.LOCKOUT(20)) dut (.mclk(mclk), .nrst(nrst), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .addr_phase_select(aps), .mode(mode),
    .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .locked(locked), .byte_pointer(byte_pointer));
  mpp_host host (.mclk(mclk), .data_out(data_out), .data_oe_n(data_oe_n),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .aps(aps), .addr(addr),
    .data_in(data_in));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic restart(input logic m);
    @(posedge mclk);
    #1;
    {nrst, mode} = {1'b0, m};
    repeat (10) @(posedge mclk);
    #1;
    nrst = 1'b1;
  endtask
  task automatic unlock;
    for (int n = 0; n < 100 && locked !== 1'b0; n++) @(posedge mclk);
    if (locked !== 1'b0) begin
      bad_count++;
      results();
    end
  endtask
  initial begin
    restart(1'b1);
    unlock();
    foreach (rows[i]) begin
      host.xfer(rows[i][21], rows[i][20], rows[i][19:8], rows[i][7:0], q);
      if (!rows[i][21]) chk({4'h0, q}, {4'h0, rows[i][7:0]});
    end
    chk(byte_pointer, 12'h000);
    // mid-run reset: a write during lockout must not land
    restart(1'b1);
    host.xfer(1'b1, 1'b0, 12'h050, 8'hee, q);
    chk({11'h000, locked}, 12'h001);
    unlock();
    host.xfer(1'b0, 1'b0, 12'h050, 8'h00, q);
    chk({4'h0, q}, 12'h033);
    restart(1'b0);
    unlock();
    // second pass reads back, walking across the 3ff to 400 carry
    for (int r = 0; r < 2; r++) begin
      host.xfer(1'b1, 1'b1, 12'h3c7, 8'hfe, q);
      chk(byte_pointer, 12'h3fe);
      for (int i = 0; i < 3; i++) begin
        // low pins differ between passes; only the pointer may matter
        host.xfer(r == 0, 1'b0, {4'h3, 8'(i * 77 + r * 40)},
                  8'(17 * i + 17), q);
        if (r == 1) chk({4'h0, q}, {4'h0, 8'(17 * i + 17)});
      end
      chk(byte_pointer, 12'h401);
    end
    results();
  end
endmodule
